// ---- core/ufc_consts.vh ----
`ifndef UFC_CONSTS_VH
`define UFC_CONSTS_VH

// ****************************************************************
// fifo control register field positions
// ****************************************************************
`define UFC_FCR_EN_BIT      0
`define UFC_FCR_RXF_BIT     1
`define UFC_FCR_TXF_BIT     2
`define UFC_FCR_DMA_BIT     3
`define UFC_FCR_BIG_BIT     5
`define UFC_FCR_TRIG_LO     6
`define UFC_FCR_TRIG_HI     7

// ****************************************************************
// reset values of the stored control fields
// ****************************************************************
`define UFC_RST_FEN         1'b0
`define UFC_RST_BIG         1'b0
`define UFC_RST_DMA         1'b0
`define UFC_RST_TRIG        2'h0

// ****************************************************************
// depths, in characters
// ****************************************************************
`define UFC_DEPTH_ONE       7'h01
`define UFC_DEPTH_SMALL     7'h10
`define UFC_DEPTH_BIG       7'h40

// ****************************************************************
// receive trigger levels, 16-byte then 64-byte operation
// ****************************************************************
`define UFC_TRIG16_0        7'h01
`define UFC_TRIG16_1        7'h04
`define UFC_TRIG16_2        7'h08
`define UFC_TRIG16_3        7'h0e
`define UFC_TRIG64_0        7'h01
`define UFC_TRIG64_1        7'h10
`define UFC_TRIG64_2        7'h20
`define UFC_TRIG64_3        7'h38

`endif

// ---- core/ufc_skid.v ----
`timescale 1ns/1ps

// two-entry buffer; both outputs and in_ready come from flip-flops
module ufc_skid (
	input  wire       sys_clk_i,
	input  wire       rst_b_i,
	input  wire       clr_i,
	input  wire       in_valid_i,
	input  wire [7:0] in_data_i,
	output wire       in_ready_o,
	output wire       out_valid_o,
	output wire [7:0] out_data_o,
	input  wire       out_ready_i
);

	reg       v0_r;
	reg       v1_r;
	reg [7:0] e0_r;
	reg [7:0] e1_r;

	wire pop  = v0_r & out_ready_i;
	wire push = in_valid_i & ~v1_r;

	assign in_ready_o  = ~v1_r;
	assign out_valid_o = v0_r;
	assign out_data_o  = e0_r;

	// ****************************************************************
	// entry 0 is the head, entry 1 catches a word during a stall
	// ****************************************************************
	always @(posedge sys_clk_i) begin
		if (!rst_b_i || clr_i) begin
			v0_r <= 1'b0;
			v1_r <= 1'b0;
			e0_r <= 8'h00;
			e1_r <= 8'h00;
		end else if (pop) begin
			if (v1_r) begin
				e0_r <= e1_r;
				v1_r <= 1'b0;
			end else begin
				v0_r <= push;
				e0_r <= in_data_i;
			end
		end else if (push) begin
			if (!v0_r) begin
				v0_r <= 1'b1;
				e0_r <= in_data_i;
			end else begin
				v1_r <= 1'b1;
				e1_r <= in_data_i;
			end
		end
	end

endmodule // ufc_skid

// ---- core/ufc_fifo_ctrl.v ----
// What this block does
// - fifo size bit picks 16 or 64
// - trigger field bits 7:6 pick level
// - rx interrupt at trigger; fill until full
// - dma select resets 0; 1 picks mode 1 only with fifo enabled
// - mode 1 tx interrupt below trigger
// - mode 1 rx interrupt at trigger
// - mode 0 tx ready low when empty
// - mode 0 rx ready low while data held
// - mode 1 tx ready high full, low emptied
// - mode 1 rx ready on trigger/timeout
// - tx flush empties fifo, self clears
// - rx flush empties fifo, self clears
// - fifo enable resets 0, enables both
// - rx interrupt drops below trigger
// - control writes only with latch bit 0
`timescale 1ns/1ps
`include "ufc_consts.vh"

module ufc_fifo_ctrl (
	input  wire       sys_clk_i,
	input  wire       rst_b_i,
	input  wire       fcr_wr_i,
	input  wire [7:0] fcr_data_i,
	input  wire       lcr_dlab_i,
	input  wire       tx_wr_i,
	input  wire [7:0] tx_wdata_i,
	output wire       tx_valid_o,
	output wire [7:0] tx_data_o,
	input  wire       tx_take_i,
	input  wire       rx_push_i,
	input  wire [7:0] rx_pdata_i,
	input  wire       rx_rd_i,
	input  wire       rx_timeout_i,
	output reg  [7:0] rx_data_o,
	output reg  [6:0] rx_count_o,
	output reg  [6:0] tx_count_o,
	output reg        rx_overrun_o,
	output reg        tx_ready_n_o,
	output reg        rx_ready_n_o,
	output reg        tx_int_o,
	output reg        rx_int_o,
	output reg  [7:0] fifo_ctrl_o
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// usable depth for the current setting
	function [6:0] ufc_cap;
		input en;
		input big;
		begin
			if (!en)
				ufc_cap = `UFC_DEPTH_ONE;
			else if (big)
				ufc_cap = `UFC_DEPTH_BIG;
			else
				ufc_cap = `UFC_DEPTH_SMALL;
		end
	endfunction

	// trigger level; a single stage triggers on one character
	function [6:0] ufc_trig;
		input [1:0] code;
		input       big;
		input       en;
		begin
			if (!en) begin
				ufc_trig = `UFC_TRIG16_0;
			end else if (big) begin
				case (code)
				2'h0:    ufc_trig = `UFC_TRIG64_0;
				2'h1:    ufc_trig = `UFC_TRIG64_1;
				2'h2:    ufc_trig = `UFC_TRIG64_2;
				default: ufc_trig = `UFC_TRIG64_3;
				endcase
			end else begin
				case (code)
				2'h0:    ufc_trig = `UFC_TRIG16_0;
				2'h1:    ufc_trig = `UFC_TRIG16_1;
				2'h2:    ufc_trig = `UFC_TRIG16_2;
				default: ufc_trig = `UFC_TRIG16_3;
				endcase
			end
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	reg        fen_r;
	reg        big_r;
	reg        dma_r;
	reg  [1:0] trig_code_r;
	reg  [7:0] tx_mem [0:63];
	reg  [7:0] rx_mem [0:63];
	reg  [5:0] tx_wp_r;
	reg  [5:0] tx_rp_r;
	reg  [5:0] rx_wp_r;
	reg  [5:0] rx_rp_r;

	reg  [6:0] tx_cnt_nxt;
	reg  [6:0] rx_cnt_nxt;
	reg  [5:0] rx_rp_nxt;
	reg  [7:0] rx_data_nxt;
	reg        tx_ready_n_nxt;
	reg        rx_ready_n_nxt;

	wire       sk_in_ready;
	wire [6:0] cap  = ufc_cap(fen_r, big_r);
	wire [6:0] trig = ufc_trig(trig_code_r, big_r, fen_r);
	wire       mode1 = fen_r & dma_r;

	// ****************************************************************
	// control register write decode
	// ****************************************************************

	// writes with the divisor latch open land elsewhere
	wire fcr_take = fcr_wr_i & ~lcr_dlab_i;
	wire new_fen  = fcr_data_i[`UFC_FCR_EN_BIT];
	wire new_big  = fcr_data_i[`UFC_FCR_BIG_BIT];
	// changing enable or size empties both, so counts never exceed cap
	wire reconf   = fcr_take & ((new_fen != fen_r) | (new_big != big_r));
	wire tx_flush = reconf |
		(fcr_take & fcr_data_i[`UFC_FCR_TXF_BIT]);
	wire rx_flush = reconf |
		(fcr_take & fcr_data_i[`UFC_FCR_RXF_BIT]);

	// ****************************************************************
	// transfer qualifiers
	// ****************************************************************
	wire tx_push = tx_wr_i & (tx_count_o < cap) & ~tx_flush;
	wire tx_pop  = (tx_count_o != 7'h00) & sk_in_ready & ~tx_flush;
	// receiver keeps loading past the trigger until full
	wire rx_ok   = rx_push_i & (rx_count_o < cap) & ~rx_flush;
	wire rx_pop  = rx_rd_i & (rx_count_o != 7'h00) & ~rx_flush;

	// stored control fields
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			fen_r       <= `UFC_RST_FEN;
			big_r       <= `UFC_RST_BIG;
			dma_r       <= `UFC_RST_DMA;
			trig_code_r <= `UFC_RST_TRIG;
		end else if (fcr_take) begin
			fen_r       <= new_fen;
			big_r       <= new_big;
			dma_r       <= fcr_data_i[`UFC_FCR_DMA_BIT];
			trig_code_r <= fcr_data_i[`UFC_FCR_TRIG_HI:`UFC_FCR_TRIG_LO];
		end
	end

	// ****************************************************************
	// next counts and read pointer
	// ****************************************************************
	always @* begin
		tx_cnt_nxt = tx_count_o;
		if (tx_flush)
			tx_cnt_nxt = 7'h00;
		else if (tx_push && !tx_pop)
			tx_cnt_nxt = tx_count_o + 7'h01;
		else if (tx_pop && !tx_push)
			tx_cnt_nxt = tx_count_o - 7'h01;

		rx_cnt_nxt = rx_count_o;
		if (rx_flush)
			rx_cnt_nxt = 7'h00;
		else if (rx_ok && !rx_pop)
			rx_cnt_nxt = rx_count_o + 7'h01;
		else if (rx_pop && !rx_ok)
			rx_cnt_nxt = rx_count_o - 7'h01;

		if (rx_flush)
			rx_rp_nxt = 6'h00;
		else if (rx_pop)
			rx_rp_nxt = rx_rp_r + 6'h01;
		else
			rx_rp_nxt = rx_rp_r;

		// bypass so the head is valid as soon as the count is
		if (rx_ok && (rx_wp_r == rx_rp_nxt))
			rx_data_nxt = rx_pdata_i;
		else
			rx_data_nxt = rx_mem[rx_rp_nxt];
	end

	// ****************************************************************
	// dma ready pins
	// ****************************************************************
	always @* begin
		if (mode1) begin
			// hysteresis: full raises it, only empty lowers it
			if (tx_cnt_nxt == cap)
				tx_ready_n_nxt = 1'b1;
			else if (tx_cnt_nxt == 7'h00)
				tx_ready_n_nxt = 1'b0;
			else
				tx_ready_n_nxt = tx_ready_n_o;
			// a trigger or time-out wins over the drain
			if ((rx_cnt_nxt >= trig) || rx_timeout_i)
				rx_ready_n_nxt = 1'b0;
			else if (rx_cnt_nxt == 7'h00)
				rx_ready_n_nxt = 1'b1;
			else
				rx_ready_n_nxt = rx_ready_n_o;
		end else begin
			tx_ready_n_nxt = (tx_cnt_nxt != 7'h00);
			rx_ready_n_nxt = (rx_cnt_nxt == 7'h00);
		end
	end

	// ****************************************************************
	// pointers, counts and status registers
	// ****************************************************************
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			tx_wp_r      <= 6'h00;
			tx_rp_r      <= 6'h00;
			rx_wp_r      <= 6'h00;
			rx_rp_r      <= 6'h00;
			tx_count_o   <= 7'h00;
			rx_count_o   <= 7'h00;
			rx_data_o    <= 8'h00;
			rx_overrun_o <= 1'b0;
			tx_ready_n_o <= 1'b0;
			rx_ready_n_o <= 1'b1;
			tx_int_o     <= 1'b1;
			rx_int_o     <= 1'b0;
			fifo_ctrl_o  <= 8'h00;
		end else begin
			if (tx_flush) begin
				tx_wp_r <= 6'h00;
				tx_rp_r <= 6'h00;
			end else begin
				if (tx_push)
					tx_wp_r <= tx_wp_r + 6'h01;
				if (tx_pop)
					tx_rp_r <= tx_rp_r + 6'h01;
			end
			if (rx_flush)
				rx_wp_r <= 6'h00;
			else if (rx_ok)
				rx_wp_r <= rx_wp_r + 6'h01;
			rx_rp_r      <= rx_rp_nxt;
			tx_count_o   <= tx_cnt_nxt;
			rx_count_o   <= rx_cnt_nxt;
			rx_data_o    <= rx_data_nxt;
			// a character that finds the fifo full is dropped
			rx_overrun_o <= rx_push_i & ~rx_ok & ~rx_flush;
			tx_ready_n_o <= tx_ready_n_nxt;
			rx_ready_n_o <= rx_ready_n_nxt;
			// interrupt conditions, rx follows the level both ways
			rx_int_o <= (rx_cnt_nxt >= trig);
			if (mode1)
				tx_int_o <= (tx_cnt_nxt < trig);
			else
				tx_int_o <= (tx_cnt_nxt == 7'h00);
			// flush bits never stored, so they read back as 0
			fifo_ctrl_o <= {trig_code_r, big_r, 1'b0, dma_r,
				2'b00, fen_r};
		end
	end

	// character storage; no reset, data is qualified by the counts
	always @(posedge sys_clk_i) begin
		if (tx_push)
			tx_mem[tx_wp_r] <= tx_wdata_i;
		if (rx_ok)
			rx_mem[rx_wp_r] <= rx_pdata_i;
	end

	// ****************************************************************
	// staging toward the shifter; the shift register itself
	// lives outside, so a flush never touches a word in flight
	// ****************************************************************
	ufc_skid u_skid (
		.sys_clk_i   (sys_clk_i),
		.rst_b_i     (rst_b_i),
		.clr_i       (tx_flush),
		.in_valid_i  (tx_pop),
		.in_data_i   (tx_mem[tx_rp_r]),
		.in_ready_o  (sk_in_ready),
		.out_valid_o (tx_valid_o),
		.out_data_o  (tx_data_o),
		.out_ready_i (tx_take_i)
	);

endmodule // ufc_fifo_ctrl

// ---- sim/ufc_fifo_ctrl_properties.sv ----
`timescale 1ns/1ps

// ****************************************************
// checker on the fifo control ports
// ****************************************************
module ufc_fifo_ctrl_properties (
	input wire       sys_clk_i,
	input wire       rst_b_i,
	input wire       fcr_wr_i,
	input wire [7:0] fcr_data_i,
	input wire       lcr_dlab_i,
	input wire       tx_wr_i,
	input wire [7:0] tx_wdata_i,
	input wire       tx_valid_o,
	input wire [7:0] tx_data_o,
	input wire       tx_take_i,
	input wire       rx_push_i,
	input wire [7:0] rx_pdata_i,
	input wire       rx_rd_i,
	input wire       rx_timeout_i,
	input wire [7:0] rx_data_o,
	input wire [6:0] rx_count_o,
	input wire [6:0] tx_count_o,
	input wire       rx_overrun_o,
	input wire       tx_ready_n_o,
	input wire       rx_ready_n_o,
	input wire       tx_int_o,
	input wire       rx_int_o,
	input wire [7:0] fifo_ctrl_o
);
	// trigger level from the readback fields
	function [6:0] trg(input [7:0] f);
		reg [27:0] t;
		begin
			t = f[5] ? {7'h38, 7'h20, 7'h10, 7'h01} :
				{7'h0e, 7'h08, 7'h04, 7'h01};
			trg = f[0] ? t[f[7:6]*7 +: 7] : 7'h01;
		end
	endfunction
	wire [7:0] f  = fifo_ctrl_o;
	wire       m1 = f[0] & f[3];
	wire [6:0] tl = trg(f);
	wire [6:0] cp = !f[0] ? 7'h01 : (f[5] ? 7'h40 : 7'h10);
	reg        wr_q;
	// readback lags one edge; skip the cycle where it is stale
	always @(posedge sys_clk_i) begin
		wr_q <= fcr_wr_i & !lcr_dlab_i;
	end
	wire ok = !wr_q;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	reset_state_a: assert property (disable iff (1'b0) !rst_b_i |=>
		f == 8'h00 && rx_count_o == 7'h00 && tx_count_o == 7'h00)
		else $error("state after reset wrong");
	readback_a: assert property (fcr_wr_i && !lcr_dlab_i |=> ##1
		f == ($past(fcr_data_i, 2) & 8'he9)) else $error("readback wrong");
	dlab_block_a: assert property (!(fcr_wr_i && !lcr_dlab_i) ##1
		(fcr_wr_i && lcr_dlab_i) ##1 !(fcr_wr_i && !lcr_dlab_i) |=>
		$stable(f)) else $error("write taken with latch bit set");
	tx_mode0_a: assert property (ok && !m1 |->
		tx_ready_n_o == (tx_count_o != 7'h00)) else $error("tx ready mode 0");
	rx_mode0_a: assert property (ok && !m1 |->
		rx_ready_n_o == (rx_count_o == 7'h00)) else $error("rx ready mode 0");
	rx_int_lvl_a: assert property (ok |->
		rx_int_o == (rx_count_o >= tl)) else $error("rx interrupt level");
	tx_int_lvl_a: assert property (ok |-> tx_int_o == (m1 ?
		tx_count_o < tl : tx_count_o == 7'h00)) else $error("tx interrupt");
	tx_mode1_a: assert property (ok && m1 && tx_count_o == cp |->
		tx_ready_n_o) else $error("tx ready not high when full");
	rx_mode1_a: assert property (ok && m1 && rx_count_o >= tl |->
		!rx_ready_n_o) else $error("rx ready not low at trigger");
	// a read in the same cycle frees a slot but the push is still lost
	rx_full_a: assert property (ok && !fcr_wr_i && rx_push_i &&
		rx_count_o == cp |=> rx_overrun_o &&
		rx_count_o == cp - {6'h00, $past(rx_rd_i)})
		else $error("push into full fifo");
	flush_a: assert property (fcr_wr_i && !lcr_dlab_i && fcr_data_i[2]
		|=> tx_count_o == 7'h00 && !tx_valid_o) else $error("tx flush");
	rx_flush_a: assert property (fcr_wr_i && !lcr_dlab_i && fcr_data_i[1]
		|=> rx_count_o == 7'h00 && f[2:1] == 2'b00) else $error("rx flush");

	cover property (ok && m1 && rx_count_o == cp);
	cover property (rx_overrun_o);
	cover property (ok && m1 && tx_count_o == cp);
endmodule // ufc_fifo_ctrl_properties

bind ufc_fifo_ctrl ufc_fifo_ctrl_properties u_props (.sys_clk_i, .rst_b_i,
	.fcr_wr_i, .fcr_data_i, .lcr_dlab_i, .tx_wr_i, .tx_wdata_i, .tx_valid_o,
	.tx_data_o, .tx_take_i, .rx_push_i, .rx_pdata_i, .rx_rd_i, .rx_timeout_i,
	.rx_data_o, .rx_count_o, .tx_count_o, .rx_overrun_o, .tx_ready_n_o,
	.rx_ready_n_o, .tx_int_o, .rx_int_o, .fifo_ctrl_o);

// ---- sim/ufc_shifter_model.sv ----
`timescale 1ns/1ps

// ****************************************************
// transmit shifter stand-in, takes words at random pace
// ****************************************************
module ufc_shifter_model (
	input  wire       sys_clk_i,
	input  wire       rst_b_i,
	input  wire       stall_i,
	input  wire       valid_i,
	input  wire [7:0] data_i,
	output reg        take_o,
	output reg        got_o,
	output reg  [7:0] got_data_o
);
	// slow answers too, so the buffer sees gaps
	always @(posedge sys_clk_i) begin
		got_o      <= rst_b_i & valid_i & take_o;
		got_data_o <= data_i;
		take_o     <= rst_b_i & !stall_i & ($urandom_range(1, 0) == 1);
	end
endmodule // ufc_shifter_model

// ---- sim/ufc_fifo_ctrl_test.sv ----
`timescale 1ns/1ps

// ****************************************************
// testbench for the fifo control block
// ****************************************************
module ufc_fifo_ctrl_test;
	reg        sys_clk_i = 0, rst_b_i = 0, fcr_wr_i = 0, lcr_dlab_i = 0;
	reg        tx_wr_i = 0, rx_push_i = 0, rx_rd_i = 0, rx_timeout_i = 0;
	reg        stall = 1;
	reg  [7:0] fcr_data_i = 0, tx_wdata_i = 0, rx_pdata_i = 0, b;
	wire       tx_valid_o, tx_take_i, rx_overrun_o, tx_ready_n_o;
	wire       rx_ready_n_o, tx_int_o, rx_int_o, got;
	wire [7:0] tx_data_o, rx_data_o, fifo_ctrl_o, got_d;
	wire [6:0] rx_count_o, tx_count_o;
	integer    fail_count = 0, tests_run = 0, i, n, k;
	reg  [6:0] tl, cp;
	reg  [7:0] q[$], tq[$], rq[$];

	ufc_fifo_ctrl u_dut (.sys_clk_i, .rst_b_i, .fcr_wr_i, .fcr_data_i,
		.lcr_dlab_i, .tx_wr_i, .tx_wdata_i, .tx_valid_o, .tx_data_o,
		.tx_take_i, .rx_push_i, .rx_pdata_i, .rx_rd_i, .rx_timeout_i,
		.rx_data_o, .rx_count_o, .tx_count_o, .rx_overrun_o, .tx_ready_n_o,
		.rx_ready_n_o, .tx_int_o, .rx_int_o, .fifo_ctrl_o);
	ufc_shifter_model u_shift (.sys_clk_i, .rst_b_i, .stall_i(stall),
		.valid_i(tx_valid_o), .data_i(tx_data_o), .take_o(tx_take_i),
		.got_o(got), .got_data_o(got_d));

	always #10 sys_clk_i = ~sys_clk_i;
	// words that left toward the shifter, in order
	always @(posedge sys_clk_i) begin
		if (got === 1'b1) rq.push_back(got_d);
	end

	function [6:0] tg(input big, input [1:0] c);
		tg = big ? (c == 0 ? 7'h01 : c == 1 ? 7'h10 : c == 2 ? 7'h20 : 7'h38)
			: (c == 0 ? 7'h01 : c == 1 ? 7'h04 : c == 2 ? 7'h08 : 7'h0e);
	endfunction
	task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] g);
		#1 tests_run = tests_run + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("wrong value %0s exp %h got %h", nm, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// each strobe is one cycle wide, sampled at the next edge;
	// the closing #1 lets outputs launched on that edge settle,
	// since chk copies its arguments the moment it is called
	task wr(input [7:0] d, input dl);
		@(posedge sys_clk_i) fcr_data_i <= d;
		fcr_wr_i   <= 1;
		lcr_dlab_i <= dl;
		@(posedge sys_clk_i) fcr_wr_i <= 0;
		lcr_dlab_i <= 0;
		#1;
	endtask
	task push(input [7:0] d);
		@(posedge sys_clk_i) rx_push_i <= 1;
		rx_pdata_i <= d;
		@(posedge sys_clk_i) rx_push_i <= 0;
		rx_pdata_i <= ~d;
		#1;
	endtask
	task txw(input [7:0] d);
		@(posedge sys_clk_i) tx_wr_i <= 1;
		tx_wdata_i <= d;
		@(posedge sys_clk_i) tx_wr_i <= 0;
		tx_wdata_i <= ~d;
		#1;
	endtask
	task rd(input [7:0] e);
		@(posedge sys_clk_i) rx_rd_i <= 1;
		chk("rx_data", e, rx_data_o);
		@(posedge sys_clk_i) rx_rd_i <= 0;
		#1;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk_i);
		fail_count = fail_count + 1;
		stop_test;
	end
	initial begin
		void'($urandom(32'hc040d2e6));
		repeat (2) @(posedge sys_clk_i);
		rst_b_i <= 1;
		chk("readback", 8'h00, fifo_ctrl_o);
		chk("tx_rdy_n", 8'h00, tx_ready_n_o);
		chk("rx_rdy_n", 8'h01, rx_ready_n_o);
		// disabled fifos keep one character only
		push(8'h5a);
		push(8'ha5);
		chk("rx_count", 8'h01, rx_count_o);
		rd(8'h5a);
		chk("rx_rdy_n", 8'h01, rx_ready_n_o);
		wr(8'h01, 1);
		repeat (2) @(posedge sys_clk_i);
		chk("readback", 8'h00, fifo_ctrl_o);
		// every size and trigger code in mode 1
		for (i = 0; i < 8; i = i + 1) begin
			wr({i[1:0], i[2], 5'h09}, 0);
			@(posedge sys_clk_i);
			#1;
			chk("readback", {i[1:0], i[2], 5'h09}, fifo_ctrl_o);
			tl = tg(i[2], i[1:0]);
			cp = i[2] ? 7'h40 : 7'h10;
			for (n = 1; n <= cp; n = n + 1) begin
				b = 8'($urandom);
				q.push_back(b);
				push(b);
				chk("rx_int", n >= tl, rx_int_o);
				chk("rx_rdy_n", n < tl, rx_ready_n_o);
			end
			push(8'h00);
			chk("overrun", 8'h01, rx_overrun_o);
			for (n = cp; n > 0; n = n - 1) begin
				rd(q.pop_front());
				chk("rx_int", n - 1 >= tl, rx_int_o);
				chk("rx_rdy_n", n == 1, rx_ready_n_o);
			end
		end
		// time-out below the trigger level
		push(8'h3c);
		@(posedge sys_clk_i) rx_timeout_i <= 1;
		@(posedge sys_clk_i) rx_timeout_i <= 0;
		#1;
		chk("rx_rdy_n", 8'h00, rx_ready_n_o);
		rd(8'h3c);
		// fill the transmit side while the shifter stalls
		for (n = 0; n < cp + 3; n = n + 1) begin
			b = 8'($urandom);
			if (n < cp + 2) tq.push_back(b);
			txw(b);
		end
		chk("tx_count", cp, tx_count_o);
		chk("tx_rdy_n", 8'h01, tx_ready_n_o);
		chk("tx_int", cp < tl, tx_int_o);
		@(posedge sys_clk_i) stall <= 0;
		for (k = 0; k < 500 && tx_count_o > 7'h08; k = k + 1)
			@(posedge sys_clk_i);
		chk("tx_rdy_n", 8'h01, tx_ready_n_o);
		for (k = 0; k < 2000 && rq.size() < cp + 2; k = k + 1)
			@(posedge sys_clk_i);
		chk("tx_rdy_n", 8'h00, tx_ready_n_o);
		chk("tx_int", 8'h01, tx_int_o);
		chk("tx_words", cp + 2, rq.size());
		while (rq.size() > 0 && tq.size() > 0)
			chk("tx_data", tq.pop_front(), rq.pop_front());
		// mode 0 with fifos on, then flush both
		@(posedge sys_clk_i) stall <= 1;
		wr(8'h01, 0);
		push(8'h11);
		push(8'h22);
		chk("rx_rdy_n", 8'h00, rx_ready_n_o);
		for (n = 0; n < 3; n = n + 1) txw(n[7:0]);
		chk("tx_rdy_n", 8'h01, tx_ready_n_o);
		wr(8'h07, 0);
		chk("rx_count", 8'h00, rx_count_o);
		chk("tx_count", 8'h00, tx_count_o);
		chk("tx_valid", 8'h00, tx_valid_o);
		@(posedge sys_clk_i);
		#1;
		chk("readback", 8'h01, fifo_ctrl_o);
		stop_test;
	end
endmodule // ufc_fifo_ctrl_test
